//--- hw/hotswap_live_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module hotswap_live_status_regs
  import hotswap_status_pkg::*;
(
  input wire logic sys_clk,                  // 125 MHz core clock
  input wire logic rst,                      // synchronous, active high
  input wire logic fb_above_pin,             // feedback above 2.56 V
  input wire logic sense_over_2mv_pin,       // sense difference above 2 mV
  input wire logic gate_pin,                 // gate drive level
  input wire logic timer_below_pin,          // fault timer below 0.2 V
  input wire logic vgs_above_pin,            // gate-source above 8 V
  input wire logic vds_below_pin,            // drain-source below 2 V
  input wire logic switch_on,                // switch turned on, core logic
  input wire logic enable_active_pin,        // enable pin in active state
  input wire logic overcurrent_pin,          // overcurrent comparator
  input wire logic input_low_pin,            // undervoltage pin level
  input wire logic input_high_pin,           // overvoltage pin level
  input wire logic power_over_limit1,        // input power over limit one
  input wire logic switch_bad,               // bad-switch condition
  input wire logic alert_pulling,            // core pulls alert low
  input wire logic bus_access_blocked,       // some registers unavailable
  input wire logic power_good_clear_select,  // config: 1 feedback low, 0 switch off
  input wire logic [SD_SOURCES-1:0] sd_event, // one-cycle shutdown events
  input wire logic rd_strobe,                // register read request
  input wire logic wr_strobe,                // register write request
  input wire logic [7:0] cmd_code,           // register command code
  input wire logic [15:0] wr_data,           // write data, ignored
  output logic [15:0] rd_data,               // read data
  output logic rd_valid,                     // read data valid pulse
  output logic rd_error,                     // unknown code pulse
  output logic [15:0] live_pin_status,       // live status image
  output logic [7:0] common_flags,           // common flags image
  output logic [7:0] shutdown_reason_record  // shutdown reason image
);

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  localparam int NPIN = 10;
  logic [NPIN-1:0] pin_raw;
  logic [NPIN-1:0] pin_meta_reg;
  logic [NPIN-1:0] pin_sync_reg;

  // gather asynchronous pins into one vector
  assign pin_raw = {fb_above_pin, sense_over_2mv_pin, gate_pin, timer_below_pin,
                    vgs_above_pin, vds_below_pin, enable_active_pin,
                    overcurrent_pin, input_low_pin, input_high_pin};

  // two flip-flops per pin, first stage feeds only the second;
  // each stage resets to its pin's idle level so no false flag follows reset
  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_sync
      always_ff @(posedge sys_clk) begin
        if (rst) begin
          pin_meta_reg[gi] <= PIN_SYNC_RESET[gi];
          pin_sync_reg[gi] <= PIN_SYNC_RESET[gi];
        end else begin
          pin_meta_reg[gi] <= pin_raw[gi];
          pin_sync_reg[gi] <= pin_meta_reg[gi];
        end
      end
    end
  endgenerate

  wire fb_s = pin_sync_reg[9];
  wire short_s = pin_sync_reg[8];
  wire gate_s = pin_sync_reg[7];
  wire timer_s = pin_sync_reg[6];
  wire vgs_s = pin_sync_reg[5];
  wire vds_s = pin_sync_reg[4];
  wire en_s = pin_sync_reg[3];
  wire oc_s = pin_sync_reg[2];
  wire uv_s = pin_sync_reg[1];
  wire ov_s = pin_sync_reg[0];

  // ----------------------------------------------------------------
  // power-good latch
  // ----------------------------------------------------------------
  logic power_good_latch_reg;
  logic power_good_latch_next;
  wire pg_set = fb_s && vgs_s && vds_s;
  wire pg_clear = power_good_clear_select ? !fb_s : !switch_on;

  // set wins over clear when both occur together
  assign power_good_latch_next = pg_set ? 1'b1 : (pg_clear ? 1'b0 : power_good_latch_reg);

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      power_good_latch_reg <= 1'b0;
    end else begin
      power_good_latch_reg <= power_good_latch_next;
    end
  end

  // ----------------------------------------------------------------
  // live status image
  // ----------------------------------------------------------------
  logic [15:0] live_next;

  // pin bits follow their synchronised sources, power_over_limit1 and switch_bad bits follow their inputs directly, reserved bits stay zero
  always_comb begin
    live_next = LIVE_STATUS_RESET;
    live_next[OUTPUT_LOST_BIT] = !fb_s && power_good_latch_reg;
    live_next[SWITCH_SHORT_BIT] = short_s && !switch_on;
    live_next[GATE_BIT] = gate_s;
    live_next[TIMER_BELOW_BIT] = timer_s;
    live_next[POWER_GOOD_LATCH_BIT] = power_good_latch_reg;
    live_next[ENABLE_BIT] = en_s;
    live_next[OVERCURRENT_BIT] = oc_s;
    live_next[INPUT_LOW_BIT] = !uv_s;
    live_next[INPUT_HIGH_BIT] = ov_s;
    live_next[POWER_LIMIT1_BIT] = power_over_limit1;
    live_next[SWITCH_BAD_BIT] = switch_bad;
  end

  // ----------------------------------------------------------------
  // common flags image
  // ----------------------------------------------------------------
  logic [7:0] common_next;
  assign common_next = {!alert_pulling, !bus_access_blocked, COMMON_RESERVED_VAL};

  // ----------------------------------------------------------------
  // shutdown reason record
  // ----------------------------------------------------------------
  logic [3:0] reason_reg;
  logic [3:0] reason_next;
  logic [3:0] reason_code [SD_SOURCES];

  // event bit i maps to code i+1
  generate
    for (gi = 0; gi < SD_SOURCES; gi++) begin : g_code
      assign reason_code[gi] = 4'(gi + 1);
    end
  endgenerate

  // lowest-numbered event wins if several arrive together
  always_comb begin
    reason_next = reason_reg;
    for (int i = SD_SOURCES - 1; i >= 0; i--) begin
      if (sd_event[i]) begin
        reason_next = reason_code[i];
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reason_reg <= SD_NONE;
    end else begin
      reason_reg <= reason_next;
    end
  end

  // ----------------------------------------------------------------
  // output images
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      live_pin_status <= LIVE_STATUS_RESET;
      common_flags <= COMMON_FLAGS_RESET;
      shutdown_reason_record <= {4'h0, SD_NONE};
    end else begin
      live_pin_status <= live_next;
      common_flags <= common_next;
      shutdown_reason_record <= {4'h0, reason_next};
    end
  end

  // ----------------------------------------------------------------
  // register read port
  // ----------------------------------------------------------------
  wire hit_live = cmd_code == LIVE_PIN_STATUS_ADDR;
  wire hit_common = cmd_code == COMMON_FLAGS_ADDR;
  wire hit_reason = cmd_code == SHUTDOWN_REASON_RECORD_ADDR;
  wire hit_any = hit_live || hit_common || hit_reason;
  logic [15:0] rd_mux;

  // address decode, unknown codes read zero
  assign rd_mux = hit_live ? live_pin_status :
                  hit_common ? {8'h00, common_flags} :
                  hit_reason ? {8'h00, shutdown_reason_record} : 16'h0000;

  // writes touch nothing in this block
  wire wr_ignored = wr_strobe && |wr_data;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rd_data <= READ_DATA_RESET;
      rd_valid <= 1'b0;
      rd_error <= 1'b0;
    end else begin
      rd_valid <= rd_strobe;
      rd_error <= (rd_strobe && !hit_any) || (wr_ignored && 1'b0);
      if (rd_strobe) begin
        rd_data <= rd_mux;
      end
    end
  end

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_OUTPUT_LOST: assert property (@(posedge sys_clk) disable iff (rst)
    live_pin_status[OUTPUT_LOST_BIT] == $past(!fb_s && power_good_latch_reg))
    else $error("output lost flag wrong");
  AST_SWITCH_SHORT: assert property (@(posedge sys_clk) disable iff (rst)
    (short_s && !switch_on) |=> live_pin_status[SWITCH_SHORT_BIT])
    else $error("switch short flag missing");
  AST_GATE: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 live_pin_status[GATE_BIT] == $past(gate_s))
    else $error("gate bit does not follow pin");
  AST_TIMER: assert property (@(posedge sys_clk) disable iff (rst)
    timer_s |=> live_pin_status[TIMER_BELOW_BIT])
    else $error("timer bit wrong");
  AST_PG_SET: assert property (@(posedge sys_clk) disable iff (rst)
    pg_set |=> ##1 live_pin_status[POWER_GOOD_LATCH_BIT])
    else $error("power good not set");
  AST_PG_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    (!pg_set && !power_good_clear_select && !switch_on) |=> !power_good_latch_reg)
    else $error("power good not cleared on switch off");
  AST_PG_FB_CLEAR: assert property (@(posedge sys_clk) disable iff (rst)
    (power_good_clear_select && !fb_s) |=> !power_good_latch_reg)
    else $error("power good not cleared on feedback low");
  AST_ENABLE: assert property (@(posedge sys_clk) disable iff (rst)
    en_s |=> live_pin_status[ENABLE_BIT])
    else $error("enable bit wrong");
  AST_OC: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(oc_s) |=> live_pin_status[OVERCURRENT_BIT])
    else $error("overcurrent bit late");
  AST_UV: assert property (@(posedge sys_clk) disable iff (rst)
    !uv_s |=> live_pin_status[INPUT_LOW_BIT])
    else $error("undervoltage bit wrong");
  AST_OV: assert property (@(posedge sys_clk) disable iff (rst)
    !ov_s |=> !live_pin_status[INPUT_HIGH_BIT])
    else $error("overvoltage bit wrong");
  AST_OP1: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(power_over_limit1) |=> !live_pin_status[POWER_LIMIT1_BIT])
    else $error("power limit bit stuck");
  AST_BAD: assert property (@(posedge sys_clk) disable iff (rst)
    switch_bad |=> live_pin_status[SWITCH_BAD_BIT])
    else $error("bad switch bit wrong");
  AST_ALERT: assert property (@(posedge sys_clk) disable iff (rst)
    alert_pulling |=> !common_flags[ALERT_N_BIT])
    else $error("alert bit wrong");
  AST_BUSY: assert property (@(posedge sys_clk) disable iff (rst)
    !bus_access_blocked |=> common_flags[BUS_BLOCKED_N_BIT])
    else $error("bus blocked bit wrong");
  AST_REASON_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (sd_event == '0) |=> $stable(reason_reg))
    else $error("reason changed without event");
  AST_REASON_CODE: assert property (@(posedge sys_clk) disable iff (rst)
    (sd_event == 13'h0080) |=> shutdown_reason_record == 8'h08)
    else $error("overcurrent cause code wrong");
  AST_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 (common_flags[5:0] == 6'h36 && shutdown_reason_record[7:4] == 4'h0))
    else $error("reserved bits changed");

  // opposite halves of the level checks and latch holding
  AST_OUTPUT_LOST_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    fb_s |=> !live_pin_status[OUTPUT_LOST_BIT])
    else $error("output lost flag while feedback good");
  AST_SHORT_ON: assert property (@(posedge sys_clk) disable iff (rst)
    switch_on |=> !live_pin_status[SWITCH_SHORT_BIT])
    else $error("switch short flag while switch on");
  AST_TIMER_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !timer_s |=> !live_pin_status[TIMER_BELOW_BIT])
    else $error("timer bit set while timer high");
  AST_PG_IMAGE: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 live_pin_status[POWER_GOOD_LATCH_BIT] == $past(power_good_latch_reg))
    else $error("power good bit does not follow latch");
  AST_PG_RISE: assert property (@(posedge sys_clk) disable iff (rst)
    $rose(power_good_latch_reg) |-> $past(pg_set))
    else $error("power good set without conditions");
  AST_PG_SW_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (power_good_latch_reg && !power_good_clear_select && switch_on) |=> power_good_latch_reg)
    else $error("power good lost while switch on");
  AST_PG_FB_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    (power_good_latch_reg && power_good_clear_select && fb_s) |=> power_good_latch_reg)
    else $error("power good lost while feedback good");
  AST_ENABLE_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !en_s |=> !live_pin_status[ENABLE_BIT])
    else $error("enable bit set while pin inactive");
  AST_OC_LEVEL: assert property (@(posedge sys_clk) disable iff (rst)
    oc_s |=> live_pin_status[OVERCURRENT_BIT])
    else $error("overcurrent bit missing");
  AST_OC_FALL: assert property (@(posedge sys_clk) disable iff (rst)
    $fell(oc_s) |=> !live_pin_status[OVERCURRENT_BIT])
    else $error("overcurrent bit stuck");
  AST_UV_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    uv_s |=> !live_pin_status[INPUT_LOW_BIT])
    else $error("undervoltage bit set while pin high");
  AST_OV_HIGH: assert property (@(posedge sys_clk) disable iff (rst)
    ov_s |=> live_pin_status[INPUT_HIGH_BIT])
    else $error("overvoltage bit missing");
  AST_OP1_SET: assert property (@(posedge sys_clk) disable iff (rst)
    power_over_limit1 |=> live_pin_status[POWER_LIMIT1_BIT])
    else $error("power limit bit missing");
  AST_BAD_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !switch_bad |=> !live_pin_status[SWITCH_BAD_BIT])
    else $error("bad switch bit set while absent");
  AST_ALERT_OFF: assert property (@(posedge sys_clk) disable iff (rst)
    !alert_pulling |=> common_flags[ALERT_N_BIT])
    else $error("alert bit low while not pulling");
  AST_BUSY_ON: assert property (@(posedge sys_clk) disable iff (rst)
    bus_access_blocked |=> !common_flags[BUS_BLOCKED_N_BIT])
    else $error("bus blocked bit high while blocked");
  AST_REASON_UPDATE: assert property (@(posedge sys_clk) disable iff (rst)
    (sd_event != '0) |=> (shutdown_reason_record[3:0] != SD_NONE))
    else $error("reason not recorded");
  AST_REASON_LOW_WINS: assert property (@(posedge sys_clk) disable iff (rst)
    sd_event[0] |=> shutdown_reason_record == 8'h01)
    else $error("operation cause code wrong");
  AST_REASON_TOP: assert property (@(posedge sys_clk) disable iff (rst)
    (sd_event == 13'h1000) |=> shutdown_reason_record == 8'h0D)
    else $error("overvoltage cause code wrong");
  AST_LIVE_RESERVED: assert property (@(posedge sys_clk) disable iff (rst)
    ##1 (live_pin_status[13:11] == 3'h0 && live_pin_status[1:0] == 2'h0))
    else $error("live reserved bits changed");

  // ----------------------------------------------------------------
  // read port checks
  // ----------------------------------------------------------------
  AST_RD_VALID: assert property (@(posedge sys_clk) disable iff (rst)
    rd_strobe |=> rd_valid)
    else $error("read not answered");
  AST_RD_HOLD: assert property (@(posedge sys_clk) disable iff (rst)
    !rd_strobe |=> $stable(rd_data))
    else $error("read data changed without read");
  AST_RD_ERROR: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_strobe && !hit_any) |=> (rd_error && rd_data == 16'h0000))
    else $error("unknown code not refused");
  AST_RD_NO_ERROR: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_strobe && hit_any) |=> !rd_error)
    else $error("known code refused");
  AST_RD_UPPER: assert property (@(posedge sys_clk) disable iff (rst)
    (rd_strobe && !hit_live) |=> rd_data[15:8] == 8'h00)
    else $error("byte register upper half not zero");
  AST_WR_NO_ANSWER: assert property (@(posedge sys_clk) disable iff (rst)
    (wr_strobe && !rd_strobe) |=> (!rd_valid && !rd_error))
    else $error("write produced an answer");

endmodule : hotswap_live_status_regs
`default_nettype wire

//--- hw/hotswap_status_pkg.sv
package hotswap_status_pkg;

  // ----------------------------------------------------------------
  // register command codes
  // ----------------------------------------------------------------
  localparam logic [7:0] LIVE_PIN_STATUS_ADDR = 8'hE5;
  localparam logic [7:0] COMMON_FLAGS_ADDR = 8'hEF;
  localparam logic [7:0] SHUTDOWN_REASON_RECORD_ADDR = 8'hF1;

  // ----------------------------------------------------------------
  // live status field positions
  // ----------------------------------------------------------------
  localparam int OUTPUT_LOST_BIT = 15;
  localparam int SWITCH_SHORT_BIT = 14;
  localparam int GATE_BIT = 10;
  localparam int TIMER_BELOW_BIT = 9;
  localparam int POWER_GOOD_LATCH_BIT = 8;
  localparam int ENABLE_BIT = 7;
  localparam int OVERCURRENT_BIT = 6;
  localparam int INPUT_LOW_BIT = 5;
  localparam int INPUT_HIGH_BIT = 4;
  localparam int POWER_LIMIT1_BIT = 3;
  localparam int SWITCH_BAD_BIT = 2;

  // ----------------------------------------------------------------
  // common flags layout and constant reserved bits
  // ----------------------------------------------------------------
  localparam int ALERT_N_BIT = 7;
  localparam int BUS_BLOCKED_N_BIT = 6;
  localparam logic [5:0] COMMON_RESERVED_VAL = 6'h36; // 11, 0, 110
  localparam logic [7:0] COMMON_FLAGS_RESET = 8'hF6;

  // ----------------------------------------------------------------
  // shutdown reason codes
  // ----------------------------------------------------------------
  localparam logic [3:0] SD_NONE = 4'h0;
  localparam logic [3:0] SD_OPERATION = 4'h1;
  localparam logic [3:0] SD_ENABLE_PIN = 4'h2;
  localparam logic [3:0] SD_REBOOT = 4'h3;
  localparam logic [3:0] SD_INT_SUPPLY_UVLO = 4'h4;
  localparam logic [3:0] SD_THERMAL = 4'h5;
  localparam logic [3:0] SD_SUPPLY_UVLO = 4'h6;
  localparam logic [3:0] SD_OVERTEMP = 4'h7;
  localparam logic [3:0] SD_OVERCURRENT = 4'h8;
  localparam logic [3:0] SD_POWER_LIMIT2 = 4'h9;
  localparam logic [3:0] SD_POWER_LIMIT1 = 4'hA;
  localparam logic [3:0] SD_SWITCH_BAD = 4'hB;
  localparam logic [3:0] SD_INPUT_LOW = 4'hC;
  localparam logic [3:0] SD_INPUT_HIGH = 4'hD;
  localparam int SD_SOURCES = 13;

  // ----------------------------------------------------------------
  // reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] LIVE_STATUS_RESET = 16'h0000;
  localparam logic [15:0] READ_DATA_RESET = 16'h0000;
  localparam logic [9:0] PIN_SYNC_RESET = 10'h002; // undervoltage pin idles high

endpackage : hotswap_status_pkg

//--- testbench/pmbus_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ---------------------------------------------------
// host side of the register read and write port
// ---------------------------------------------------
module pmbus_host_model (
  input wire logic sys_clk,        // core clock
  input wire logic [15:0] rd_data, // read data
  input wire logic rd_valid,       // read answer pulse
  input wire logic rd_error,       // unknown code pulse
  output logic rd_strobe,          // read request
  output logic wr_strobe,          // write request
  output logic [7:0] cmd_code,     // register code
  output logic [15:0] wr_data      // write data
);
  // idle levels at time zero
  initial begin
    rd_strobe = 1'b0;
    wr_strobe = 1'b0;
    cmd_code = 8'h00;
    wr_data = 16'h0000;
  end
  // one read, after gap + 1 idle cycles; released code shows its inverse
  task automatic read(input int gap, input logic [7:0] c, output logic [15:0] d,
                      output logic err, output logic ok);
    int i;
    ok = 1'b0;
    d = 16'h0000;
    err = 1'b0;
    repeat (gap) @(negedge sys_clk);
    @(negedge sys_clk);
    rd_strobe = 1'b1;
    cmd_code = c;
    @(negedge sys_clk);
    rd_strobe = 1'b0;
    cmd_code = ~c;
    for (i = 0; i < 4 && !ok; i++) begin
      if (rd_valid === 1'b1) begin
        ok = 1'b1;
        d = rd_data;
        err = rd_error;
      end else @(negedge sys_clk);
    end
  endtask : read
  // one write, which the block must ignore
  task automatic write(input logic [7:0] c, input logic [15:0] d);
    @(negedge sys_clk);
    wr_strobe = 1'b1;
    cmd_code = c;
    wr_data = d;
    @(negedge sys_clk);
    wr_strobe = 1'b0;
    cmd_code = ~c;
    wr_data = ~d;
  endtask : write
endmodule : pmbus_host_model
`default_nettype wire

//--- testbench/tb.sv
`timescale 1ns/1ps
`default_nettype none
module tb;
  import hotswap_status_pkg::*;
  logic sys_clk, rst, fb, vgs, vds, sw_on, alert, blocked, sel;
  logic [8:0] pin;
  logic [SD_SOURCES-1:0] sd_event;
  logic rd_strobe, wr_strobe, rd_valid, rd_error;
  logic [7:0] cmd_code, common_img, reason_img;
  logic [15:0] wr_data, rd_data, live_img;
  int n_fail, comparisons;
  // status bit set when pin i leaves its idle level
  localparam int PIN_BIT [9] = '{14, 10, 9, 7, 6, 5, 4, 3, 2};
  localparam logic [8:0] PIN_BASE = 9'h020; // undervoltage pin idles high

  hotswap_live_status_regs u_dut (.sys_clk(sys_clk), .rst(rst), .fb_above_pin(fb),
    .sense_over_2mv_pin(pin[0]), .gate_pin(pin[1]), .timer_below_pin(pin[2]),
    .vgs_above_pin(vgs), .vds_below_pin(vds), .switch_on(sw_on),
    .enable_active_pin(pin[3]), .overcurrent_pin(pin[4]), .input_low_pin(pin[5]),
    .input_high_pin(pin[6]), .power_over_limit1(pin[7]), .switch_bad(pin[8]),
    .alert_pulling(alert), .bus_access_blocked(blocked), .power_good_clear_select(sel),
    .sd_event(sd_event), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .cmd_code(cmd_code), .wr_data(wr_data), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_error(rd_error), .live_pin_status(live_img), .common_flags(common_img),
    .shutdown_reason_record(reason_img));
  pmbus_host_model u_host (.sys_clk(sys_clk), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_error(rd_error), .rd_strobe(rd_strobe), .wr_strobe(wr_strobe),
    .cmd_code(cmd_code), .wr_data(wr_data));

  // ---------------------------------------------------
  // clock and shared tasks
  // ---------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : conclude
  task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // read a register and compare data and error pulse
  task automatic rd_chk(input string nm, input logic [7:0] c, input logic [15:0] exp,
                        input logic exp_err);
    logic [15:0] d;
    logic err, ok;
    u_host.read(comparisons % 3, c, d, err, ok);
    if (!ok) begin
      n_fail++;
      $display("[FAIL] %s expected answer seen none", nm);
      conclude();
    end else begin
      check(nm, d, exp);
      check({nm, " error"}, {15'h0000, err}, {15'h0000, exp_err});
      if (c == LIVE_PIN_STATUS_ADDR) check({nm, " image"}, live_img, exp);
      else if (c == COMMON_FLAGS_ADDR) check({nm, " image"}, {8'h00, common_img}, exp);
      else if (c == SHUTDOWN_REASON_RECORD_ADDR) check({nm, " image"}, {8'h00, reason_img}, exp);
    end
  endtask : rd_chk
  task automatic settle();
    repeat (6) @(negedge sys_clk);
  endtask : settle

  // ---------------------------------------------------
  // scenarios
  // ---------------------------------------------------
  task automatic test_reset();
    rd_chk("live", LIVE_PIN_STATUS_ADDR, 16'h0000, 1'b0);
    rd_chk("common", COMMON_FLAGS_ADDR, 16'h00F6, 1'b0);
    rd_chk("reason", SHUTDOWN_REASON_RECORD_ADDR, 16'h0000, 1'b0);
    rd_chk("unknown", 8'hE6, 16'h0000, 1'b1);
    u_host.write(COMMON_FLAGS_ADDR, 16'h0000);
    rd_chk("common written", COMMON_FLAGS_ADDR, 16'h00F6, 1'b0);
    $display("test reset done");
  endtask : test_reset
  task automatic test_pins();
    for (int i = 0; i < 9; i++) begin
      pin = PIN_BASE ^ (9'h001 << i);
      settle();
      rd_chk("live pin", LIVE_PIN_STATUS_ADDR, 16'h0001 << PIN_BIT[i], 1'b0);
    end
    pin = PIN_BASE | 9'h001;
    sw_on = 1'b1;
    settle();
    rd_chk("short while on", LIVE_PIN_STATUS_ADDR, 16'h0000, 1'b0);
    pin = PIN_BASE;
    sw_on = 1'b0;
    settle();
    rd_chk("pins idle", LIVE_PIN_STATUS_ADDR, 16'h0000, 1'b0);
    $display("test pins done");
  endtask : test_pins
  task automatic test_power_good();
    {sel, fb, vgs, vds, sw_on} = 5'b01111;
    settle();
    rd_chk("pg set", LIVE_PIN_STATUS_ADDR, 16'h0100, 1'b0);
    fb = 1'b0;
    settle();
    rd_chk("output lost", LIVE_PIN_STATUS_ADDR, 16'h8100, 1'b0);
    sw_on = 1'b0;
    settle();
    rd_chk("pg off clear", LIVE_PIN_STATUS_ADDR, 16'h0000, 1'b0);
    {sel, fb, vgs, vds, sw_on} = 5'b11111;
    settle();
    {vgs, vds, sw_on} = 3'b000;
    settle();
    rd_chk("pg holds off", LIVE_PIN_STATUS_ADDR, 16'h0100, 1'b0);
    fb = 1'b0;
    settle();
    rd_chk("pg fb clear", LIVE_PIN_STATUS_ADDR, 16'h0000, 1'b0);
    $display("test power good done");
  endtask : test_power_good
  task automatic test_common();
    alert = 1'b1;
    settle();
    rd_chk("alert", COMMON_FLAGS_ADDR, 16'h0076, 1'b0);
    alert = 1'b0;
    blocked = 1'b1;
    settle();
    rd_chk("blocked", COMMON_FLAGS_ADDR, 16'h00B6, 1'b0);
    blocked = 1'b0;
    $display("test common done");
  endtask : test_common
  task automatic test_shutdown();
    for (int i = 0; i < SD_SOURCES; i++) begin
      @(negedge sys_clk);
      sd_event = 13'h0001 << i;
      @(negedge sys_clk);
      sd_event = '0;
      rd_chk("cause", SHUTDOWN_REASON_RECORD_ADDR, 16'(i + 1), 1'b0);
    end
    @(negedge sys_clk);
    sd_event = 13'h0210;
    @(negedge sys_clk);
    sd_event = '0;
    u_host.write(SHUTDOWN_REASON_RECORD_ADDR, 16'hFFFF);
    rd_chk("cause pair", SHUTDOWN_REASON_RECORD_ADDR, 16'h0005, 1'b0);
    rst = 1'b1;
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    rd_chk("cause reset", SHUTDOWN_REASON_RECORD_ADDR, 16'h0000, 1'b0);
    $display("test shutdown done");
  endtask : test_shutdown

  // ---------------------------------------------------
  // main sequence
  // ---------------------------------------------------
  initial begin
    rst = 1'b1;
    {fb, vgs, vds, sw_on, alert, blocked, sel} = 7'h00;
    pin = PIN_BASE;
    sd_event = '0;
    n_fail = 0;
    comparisons = 0;
    repeat (4) @(negedge sys_clk);
    rst = 1'b0;
    test_reset();
    test_pins();
    test_power_good();
    test_common();
    test_shutdown();
    conclude();
  end
endmodule : tb
`default_nettype wire
